// [verilog/lpmrs_top.sv]
// low-power mode sequencing and reset/break status registers
//
// Overview of operation
// - wait or stop clears cpu interrupt mask
// - wait stops cpu clock, peripherals run
// - enabled interrupt wakes cpu from wait
// - reset or break also ends wait
// - exit is reset pin, irq or break
// - break in wait/stop sets break flag
// - watchdog runs in wait unless disabled
// - stop resets counter, gates all clocks
// - oscillator outputs gated during stop
// - stop exit waits for recovery time
// - recovery 4096 or 32 slow cycles
// - counter held reset until recovery begins
// - break flag cleared by zero, reset
// - reading reset cause register clears it
// - power-on sets por, clears others
// - one cause flag per reset source, but a mode cause is latched only together with another cause
// - monitor entry flag on blank vector
// - break-state clearing needs clear enable; only status_clear_allow follows it, cause read and flag clears do not
// - two-step clears stay protected in break
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module lpmrs_top
   import lpmrs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   // cpu side
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic cpu_irq,
   input wire logic break_irq,
   input wire logic in_break,
   input wire logic rst_pin,
   input wire logic slow_tick,
   input wire lpmrs_cause_s cause_in,
   input wire logic vector_blank,
   input wire logic irq_pin_high,
   output logic clear_imask,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_clock_out_en,
   output logic wdog_run,
   output logic irq_stack_go,
   output logic status_clear_allow,
   output logic two_step_arm_allow
);
   // bus capture
   logic wr_pend_q;
   logic wr_pend_d;
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic [31:0] rdata_d;
   // registers
   logic break_wake_flag_q;
   logic break_wake_flag_d;
   logic [7:0] reset_cause_q;
   logic [7:0] reset_cause_d;
   logic break_clear_enable_q;
   logic short_recovery_select_q;
   logic watchdog_disable_option_q;
   // sequencer
   lpmrs_mode_e mode_q;
   lpmrs_mode_e mode_d;
   logic [12:0] sys_cnt_q;
   logic [12:0] sys_cnt_d;
   logic was_break_q;
   logic stack_d;
   // stacking request delayed one cycle so the cpu clock is back first
   logic stack_q;

   // decode
   wire access = hsel & hready & (htrans == LPMRS_HTRANS_NONSEQ);
   wire rd_go = access & ~hwrite;
   wire wr_go = access & hwrite;
   wire rd_cause = rd_go & (haddr == LPMRS_RST_CAUSE_ADDR);
   wire wr_brk = wr_pend_q & (addr_q == LPMRS_BRK_STAT_ADDR);
   wire wr_ctl = wr_pend_q & (addr_q == LPMRS_BRK_CTRL_ADDR);
   wire wr_cfg = wr_pend_q & (addr_q == LPMRS_CONFIG_ADDR);
   // exit condition: reset pin, irq or break
   wire lowpower_exit = rst_pin | cpu_irq | break_irq;
   wire in_lowpwr = (mode_q == LPMRS_WAIT) | (mode_q == LPMRS_STOP);
   wire rec_limit_hit = short_recovery_select_q ? (sys_cnt_q >= LPMRS_REC_SHORT)
                                                : (sys_cnt_q >= LPMRS_REC_LONG);
   // break wake only when break ends a low-power period
   wire brk_wake_set = in_lowpwr & break_irq;

   // next mode
   always_comb
   begin
      mode_d = mode_q;
      sys_cnt_d = sys_cnt_q;
      stack_d = 1'b0;
      case (mode_q)
         LPMRS_RUN:
         begin
            if (stop_exec)
            begin
               mode_d = LPMRS_STOP;
               sys_cnt_d = 13'h0000;
            end
            else if (wait_exec)
               mode_d = LPMRS_WAIT;
         end
         LPMRS_WAIT:
         begin
            // stacking one cycle later via registered pulse
            if (lowpower_exit)
            begin
               mode_d = LPMRS_RUN;
               stack_d = cpu_irq | break_irq;
            end
         end
         LPMRS_STOP:
         begin
            sys_cnt_d = 13'h0000; // held in reset
            if (lowpower_exit)
               mode_d = LPMRS_RECOVER;
         end
         LPMRS_RECOVER:
         begin
            // count slow clock cycles only
            if (rec_limit_hit)
            begin
               mode_d = LPMRS_RUN;
               stack_d = ~was_break_q | 1'b1;
            end
            else if (slow_tick)
               sys_cnt_d = 13'(sys_cnt_q + 13'h0001);
         end
         default:
            mode_d = LPMRS_RUN;
      endcase
   end

   // break wake flag: set wins over software clear
   always_comb
   begin
      break_wake_flag_d = break_wake_flag_q;
      if (wr_brk & ~hwdata[LPMRS_BRK_WAKE_BIT])
         break_wake_flag_d = 1'b0;
      if (brk_wake_set)
         break_wake_flag_d = 1'b1;
   end

   // reset cause: read clears, power-on or live cause overrides
   always_comb
   begin
      reset_cause_d = reset_cause_q;
      if (rd_cause)
         reset_cause_d = 8'h00;
   end

   // read data mux
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (haddr)
         LPMRS_BRK_STAT_ADDR: rdata_d[LPMRS_BRK_WAKE_BIT] = break_wake_flag_q;
         LPMRS_RST_CAUSE_ADDR: rdata_d[7:0] = reset_cause_q;
         LPMRS_BRK_CTRL_ADDR: rdata_d[LPMRS_CLR_EN_BIT] = break_clear_enable_q;
         LPMRS_CONFIG_ADDR:
         begin
            rdata_d[LPMRS_SHORT_REC_BIT] = short_recovery_select_q;
            rdata_d[LPMRS_WDOG_DIS_BIT] = watchdog_disable_option_q;
         end
         LPMRS_MODE_ADDR: rdata_d[3:0] = mode_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   assign wr_pend_d = wr_go;
   assign addr_d = haddr;

   // bus phase registers; zero wait states
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         addr_q <= addr_d;
         if (rd_go)
            hrdata <= rdata_d;
      end
   end

   // constant bus answers, still from flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= LPMRS_HRESP_OKAY;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= LPMRS_HRESP_OKAY;
      end
   end

   // status and control registers; any reset clears the break flag
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         break_wake_flag_q <= 1'b0;
         break_clear_enable_q <= LPMRS_BRK_CTRL_RST[LPMRS_CLR_EN_BIT];
         short_recovery_select_q <= LPMRS_CONFIG_RST[LPMRS_SHORT_REC_BIT];
         watchdog_disable_option_q <= LPMRS_CONFIG_RST[LPMRS_WDOG_DIS_BIT];
      end
      else
      begin
         break_wake_flag_q <= break_wake_flag_d;
         if (wr_ctl)
            break_clear_enable_q <= hwdata[LPMRS_CLR_EN_BIT];
         // crystal users should leave this clear
         if (wr_cfg)
         begin
            short_recovery_select_q <= hwdata[LPMRS_SHORT_REC_BIT];
            watchdog_disable_option_q <= hwdata[LPMRS_WDOG_DIS_BIT];
         end
      end
   end

   // reset cause flags are caught after release from the reset generator
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         reset_cause_q <= 8'h00;
      else if (cause_in.por)
         // power-on wipes the rest; blank vector at por gives monitor entry
         reset_cause_q <= {1'b1, 4'h0, (vector_blank & irq_pin_high), 2'b00};
      else if (|{cause_in.pin, cause_in.wdog, cause_in.bad_op, cause_in.bad_addr,
                 cause_in.low_volt})
      begin
         reset_cause_q <= 8'h00;
         reset_cause_q[LPMRS_RC_PIN] <= cause_in.pin;
         reset_cause_q[LPMRS_RC_WDOG] <= cause_in.wdog;
         reset_cause_q[LPMRS_RC_BADOP] <= cause_in.bad_op;
         reset_cause_q[LPMRS_RC_BADADR] <= cause_in.bad_addr;
         reset_cause_q[LPMRS_RC_MODE] <= cause_in.mode;
         reset_cause_q[LPMRS_RC_LOWV] <= cause_in.low_volt;
      end
      else
         reset_cause_q <= reset_cause_d;
   end

   // sequencer state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q <= LPMRS_RUN;
         sys_cnt_q <= 13'h0000;
         was_break_q <= 1'b0;
         stack_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         sys_cnt_q <= sys_cnt_d;
         // one cycle between clock restart and stacking
         stack_q <= stack_d;
         if (in_lowpwr & lowpower_exit)
            was_break_q <= break_irq;
      end
   end

   // registered outputs toward cpu and peripherals
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clear_imask <= 1'b0;
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         osc_clock_out_en <= 1'b1;
         wdog_run <= 1'b1;
         irq_stack_go <= 1'b0;
         status_clear_allow <= 1'b1;
         two_step_arm_allow <= 1'b1;
      end
      else
      begin
         clear_imask <= (mode_q == LPMRS_RUN) & (wait_exec | stop_exec);
         cpu_clk_en <= (mode_d == LPMRS_RUN);
         periph_clk_en <= (mode_d == LPMRS_RUN) | (mode_d == LPMRS_WAIT);
         osc_clock_out_en <= (mode_d != LPMRS_STOP) & (mode_d != LPMRS_RECOVER);
         // watchdog stays live in wait unless option set; slow clock keeps it in stop
         wdog_run <= ~watchdog_disable_option_q;
         irq_stack_go <= stack_q;
         status_clear_allow <= ~in_break | break_clear_enable_q;
         // first step of a two-step clear may not arm during break
         two_step_arm_allow <= ~in_break;
      end
   end
endmodule // lpmrs_top

// [verilog/lpmrs_pkg.sv]
// package for the low-power mode and reset status block
package lpmrs_pkg;
   // register byte addresses (chosen layout)
   localparam logic [7:0] LPMRS_BRK_STAT_ADDR = 8'h00;
   localparam logic [7:0] LPMRS_RST_CAUSE_ADDR = 8'h04;
   localparam logic [7:0] LPMRS_BRK_CTRL_ADDR = 8'h08;
   localparam logic [7:0] LPMRS_CONFIG_ADDR = 8'h0C;
   localparam logic [7:0] LPMRS_MODE_ADDR = 8'h10;
   // break status field
   localparam int LPMRS_BRK_WAKE_BIT = 1;
   // break flag clear control field
   localparam int LPMRS_CLR_EN_BIT = 7;
   // config register fields
   localparam int LPMRS_SHORT_REC_BIT = 0;
   localparam int LPMRS_WDOG_DIS_BIT = 1;
   // reset cause fields
   localparam int LPMRS_RC_LOWV = 1;
   localparam int LPMRS_RC_MODE = 2;
   localparam int LPMRS_RC_BADADR = 3;
   localparam int LPMRS_RC_BADOP = 4;
   localparam int LPMRS_RC_WDOG = 5;
   localparam int LPMRS_RC_PIN = 6;
   localparam int LPMRS_RC_POR = 7;
   // reset values
   localparam logic [7:0] LPMRS_BRK_CTRL_RST = 8'h00;
   localparam logic [7:0] LPMRS_CONFIG_RST = 8'h00;
   // recovery counts in slow clock cycles
   localparam logic [12:0] LPMRS_REC_LONG = 13'h1000;
   localparam logic [12:0] LPMRS_REC_SHORT = 13'h0020;
   // ahb codes
   localparam logic [1:0] LPMRS_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] LPMRS_HRESP_OKAY = 2'h0;
   // power modes, one-hot
   typedef enum logic [3:0]
   {
      LPMRS_RUN = 4'h1,
      LPMRS_WAIT = 4'h2,
      LPMRS_STOP = 4'h4,
      LPMRS_RECOVER = 4'h8
   } lpmrs_mode_e;
   // reset causes reported by the reset generator
   typedef struct packed
   {
      logic por;
      logic pin;
      logic wdog;
      logic bad_op;
      logic bad_addr;
      logic mode;
      logic low_volt;
   } lpmrs_cause_s;
endpackage

// [tb/lpmrs_top_asserts.sv]
// checker on the power-mode and status outputs
`timescale 1ns/10ps
module lpmrs_top_asserts
   import lpmrs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic cpu_irq,
   input wire logic break_irq,
   input wire logic in_break,
   input wire logic rst_pin,
   input wire logic slow_tick,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_clock_out_en,
   input wire logic clear_imask,
   input wire logic irq_stack_go,
   input wire logic status_clear_allow,
   input wire logic two_step_arm_allow
);
   wire run = cpu_clk_en; // cpu clocked only in run
   wire ext = cpu_irq | break_irq | rst_pin; // any wake source
   logic rec_q; // exit seen while gated
   logic [12:0] tk_q; // slow ticks since exit
   // tick count lives only while peripherals are gated
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rec_q <= 1'h0;
         tk_q <= 13'h0000;
      end
      else
      begin
         rec_q <= !periph_clk_en && (rec_q || ext);
         tk_q <= periph_clk_en ? 13'h0000 : tk_q + 13'(rec_q && slow_tick);
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wake;
      cpu_clk_en ##1 irq_stack_go;
   endsequence
   sequence s_rec_done;
      tk_q >= 13'h0020 ##[0:1] irq_stack_go;
   endsequence
   a_imask_clear: assert property ((wait_exec || stop_exec) && run |=> clear_imask)
      else $error("mask not cleared");
   a_wait_gate: assert property (wait_exec && !stop_exec && run && !ext
      |=> !cpu_clk_en && periph_clk_en) else $error("wait gating wrong");
   a_wait_wake: assert property (!run && periph_clk_en && (cpu_irq || break_irq)
      |=> s_wake) else $error("wait wake wrong");
   a_wait_reset: assert property (!run && periph_clk_en && rst_pin |=> cpu_clk_en)
      else $error("reset did not end wait");
   a_stop_gate: assert property (stop_exec && !wait_exec && run && !ext
      |=> !cpu_clk_en && !periph_clk_en && !osc_clock_out_en) else $error("stop gating");
   a_stop_hold: assert property (!periph_clk_en && !rec_q && !ext |=> !cpu_clk_en)
      else $error("left stop early");
   a_rec_time: assert property ($rose(periph_clk_en) |-> s_rec_done)
      else $error("recovery too short");
   a_break_arm: assert property (in_break |=> !two_step_arm_allow)
      else $error("arm allowed in break");
   a_run_allow: assert property (!in_break |=> status_clear_allow && two_step_arm_allow)
      else $error("clear blocked in run");
endmodule // lpmrs_top_asserts

// [tb/lpmrs_cpu_model.sv]
// cpu core model: instruction pulses and slow clock ticks
`timescale 1ns/10ps
module lpmrs_cpu_model
(
   input wire logic hclk,
   output logic wait_exec,
   output logic stop_exec,
   output logic slow_tick
);
   logic [1:0] div_q = 2'h0; // free running slow clock divider
   initial {wait_exec, stop_exec, slow_tick} = 3'h0;
   // slow oscillator never stops, so ticks run in stop too
   always @(posedge hclk)
   begin
      div_q <= div_q + 2'h1;
      slow_tick <= (div_q == 2'h3);
   end
   // one-cycle instruction pulse, stop when stp is set
   task automatic exec_op(input logic stp);
      @(posedge hclk);
      wait_exec <= !stp;
      stop_exec <= stp;
      @(posedge hclk);
      wait_exec <= 1'h0;
      stop_exec <= 1'h0;
   endtask
endmodule // lpmrs_cpu_model

// [tb/lpmrs_top_tb_top.sv]
// self-checking bench for the power-mode and status block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module lpmrs_top_tb_top
   import lpmrs_pkg::*;
   ;
   logic hclk, hresetn, hsel, hwrite, hreadyout, dph, cpu_irq, break_irq, in_break, rst_pin;
   logic vector_blank, irq_pin_high, clear_imask, cpu_clk_en, periph_clk_en, osc_clock_out_en;
   logic wdog_run, irq_stack_go, status_clear_allow, two_step_arm_allow;
   logic wait_exec, stop_exec, slow_tick;
   logic [7:0] haddr;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   lpmrs_cause_s cause_in;
   logic [31:0] exp_q[$]; // expected read data, oldest first
   int fail_count = 0;
   int n_compared = 0;
   int stk = 0; // stacking pulses seen
   int s0, k;
   lpmrs_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .wait_exec, .stop_exec, .cpu_irq,
      .break_irq, .in_break, .rst_pin, .slow_tick, .cause_in, .vector_blank, .irq_pin_high,
      .clear_imask, .cpu_clk_en, .periph_clk_en, .osc_clock_out_en, .wdog_run, .irq_stack_go,
      .status_clear_allow, .two_step_arm_allow);
   lpmrs_cpu_model u_cpu (.hclk, .wait_exec, .stop_exec, .slow_tick);
   initial
   begin
      hclk = 1'h0;
      forever #20 hclk = ~hclk;
   end
   // monitor: read data against oldest note, count stacking pulses
   always @(posedge hclk)
   begin
      if (irq_stack_go === 1'h1)
         stk++;
      if (dph && hreadyout === 1'h1)
         `CHK(hrdata, exp_q.pop_front())
   end
   task automatic end_of_test;
      $display("mismatches %0d compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // bounded wait for the slave's ready
   task automatic rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'h1 && n < 50);
      if (n >= 50)
      begin
         fail_count++;
         end_of_test;
      end
   endtask
   // one ahb-lite single word transfer, address then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= LPMRS_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      rdy;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      dph <= !w;
      rdy;
      dph <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'h0, a, 32'h0);
   endtask
   // bounded wait for the cpu clock to come back
   task automatic wake(input int n, output int c);
      c = 0;
      while (cpu_clk_en !== 1'h1)
      begin
         @(posedge hclk);
         #1;
         c++;
         if (c > n)
         begin
            fail_count++;
            end_of_test;
         end
      end
   endtask
   // reset, then one cause pulse, then read twice
   task automatic cause(input lpmrs_cause_s c, input logic [7:0] e);
      hresetn <= 1'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      cause_in <= c;
      @(posedge hclk);
      cause_in <= '0;
      rd(LPMRS_RST_CAUSE_ADDR, {24'h0, e});
      rd(LPMRS_RST_CAUSE_ADDR, 32'h0);
   endtask
   initial
   begin
      {hresetn, hsel, hwrite, cpu_irq, break_irq, in_break, rst_pin, dph} = '0;
      {haddr, htrans, hwdata, cause_in} = '0;
      hsize = 3'h2;
      {vector_blank, irq_pin_high} = 2'h3;
      void'($urandom(94260));
      cause(7'h40, 8'h84);
      vector_blank <= 1'h0;
      for (int i = 0; i < 7; i++)
         if (i != 1)
            cause(7'(1 << i), 8'(2 << i));
      bus(1'h1, 8'h20, $urandom());
      rd(8'h20, 32'h0);
      in_break <= 1'h1;
      bus(1'h1, LPMRS_BRK_CTRL_ADDR, 32'h80);
      rd(LPMRS_BRK_CTRL_ADDR, 32'h80);
      #1 `CHK({status_clear_allow, two_step_arm_allow}, 2'h2)
      bus(1'h1, LPMRS_BRK_CTRL_ADDR, 32'h0);
      rd(LPMRS_BRK_CTRL_ADDR, 32'h0);
      #1 `CHK({status_clear_allow, two_step_arm_allow}, 2'h0)
      {in_break, break_irq} <= 2'h1;
      repeat (2) @(posedge hclk);
      break_irq <= 1'h0;
      rd(LPMRS_BRK_STAT_ADDR, 32'h0);
      bus(1'h1, LPMRS_CONFIG_ADDR, 32'h0);
      // wake from wait by irq, break, then reset pin
      for (int s = 0; s < 3; s++)
      begin
         u_cpu.exec_op(1'h0);
         #1 `CHK({cpu_clk_en, periph_clk_en, wdog_run}, 3'h3)
         rd(LPMRS_MODE_ADDR, 32'h2);
         s0 = stk;
         {rst_pin, break_irq, cpu_irq} <= 3'(1 << s);
         wake(20, k);
         {rst_pin, break_irq, cpu_irq} <= 3'h0;
         repeat (2) @(posedge hclk);
         #1 `CHK(stk - s0, int'(s < 2))
         rd(LPMRS_BRK_STAT_ADDR, (s == 1) ? 32'h2 : 32'h0);
         bus(1'h1, LPMRS_BRK_STAT_ADDR, 32'h0);
         rd(LPMRS_BRK_STAT_ADDR, 32'h0);
      end
      // stop: short recovery left by break, long one left by irq
      for (int s = 0; s < 2; s++)
      begin
         bus(1'h1, LPMRS_CONFIG_ADDR, 32'(s == 0));
         u_cpu.exec_op(1'h1);
         #1 `CHK({cpu_clk_en, periph_clk_en, osc_clock_out_en}, 3'h0)
         rd(LPMRS_MODE_ADDR, 32'h4);
         repeat ($urandom_range(40, 5)) @(posedge hclk);
         #1 `CHK(cpu_clk_en, 1'h0)
         s0 = stk;
         {break_irq, cpu_irq} <= (s == 0) ? 2'h2 : 2'h1;
         wake(20000, k);
         {break_irq, cpu_irq} <= 2'h0;
         `CHK(k >= (s ? 16380 : 124) && k <= (s ? 16396 : 140), 1'h1)
         repeat (2) @(posedge hclk);
         #1 `CHK(stk - s0, 1)
         rd(LPMRS_BRK_STAT_ADDR, (s == 0) ? 32'h2 : 32'h0);
         bus(1'h1, LPMRS_BRK_STAT_ADDR, 32'h0);
      end
      end_of_test;
   end
endmodule // lpmrs_top_tb_top
bind lpmrs_top lpmrs_top_asserts u_chk (.hclk, .hresetn, .wait_exec, .stop_exec, .cpu_irq,
   .break_irq, .in_break, .rst_pin, .slow_tick, .cpu_clk_en, .periph_clk_en, .osc_clock_out_en,
   .clear_imask, .irq_stack_go, .status_clear_allow, .two_step_arm_allow);
